/* File: rtl/eeprom_pkg.sv */
// shared constants and types of the serial eeprom slave
package eeprom_pkg;

    // command opcodes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_SR_READ   = 8'h05;
    localparam logic [7:0] OP_SR_WRITE  = 8'h01;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_WRITE     = 8'h02;

    // status bit positions
    localparam int SR_GUARD_EN  = 7;
    localparam int SR_ID_SEL    = 6;
    localparam int SR_ZERO      = 5;
    localparam int SR_ID_LOCK   = 4;
    localparam int SR_BG_HIGH   = 3;
    localparam int SR_BG_LOW    = 2;
    localparam int SR_LATCH     = 1;
    localparam int SR_BUSY      = 0;

    // bits that a status write may change
    localparam logic [7:0] SR_WRITE_MASK = 8'hdc;
    localparam logic [7:0] SR_RESET      = 8'h00;

    // geometry
    localparam int ARRAY_ADDR_W = 15;
    localparam int ID_ADDR_W    = 6;
    localparam int FIFO_DEPTH   = 8;

    // self-timed programming time; value is a plain default
    localparam longint WRITE_TIME_NS = 64'd5000000;
    localparam longint CLK_PERIOD_NS = 64'd40;
    localparam int     WRITE_CYCLES  = int'((WRITE_TIME_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);

    // pins after the synchroniser
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
        logic hold_n;
        logic wp_n;
    } pins_t;

    // one byte waiting to be programmed
    typedef struct packed {
        logic                    is_id;
        logic [ARRAY_ADDR_W-1:0] addr;
        logic [7:0]              data;
    } wr_entry_t;

endpackage : eeprom_pkg

/* File: rtl/spi_eeprom.sv */
// serial eeprom slave: command decode, status register, reads, hold and self-timed write
// Summary of operation
// - status write changes only bits 2, 3, 4, 6 and 7
// - guard pin low with guard enable set rejects status writes
// - guard pin falling while selected with guard enable set aborts the pending status write
// - once programming started the guard pin no longer matters
// - guard enable clear makes the guard pin level irrelevant
// - read opcode plus 16-bit address; data follows the last address bit
// - sequential read advances the address after each byte shifted out
// - read address wraps from the top location to zero
// - deselect ends a read and stops the output
// - id page read needs page select; A5..A0 pick the byte
// - id page read keeps incrementing the six-bit page address
// - status read is accepted anytime, also while busy, full contents
// - hold active: output high impedance, input transitions ignored
// - after reset: standby, write latch cleared
// - an instruction is taken only after select falls
// - completed write of any kind clears the write latch
// - programming starts only on deselect after the exact clock count
// - while busy, commands other than status read are ignored
// - unknown opcode: no action, output stays high impedance
// - opcode encodings for latch set/clear, status read/write, read, write
// - status layout: guard enable, page select, 0, lock, guards, latch, busy
// - busy flag reads one through programming, zero when ready
// - array accesses use the low 15 address bits only
`timescale 1ns/1ps

module wr_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             flush,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_depth_chk
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wp_q, wp_d, rp_q, rp_d;

    assign in_ready  = (wp_q - rp_q) != (PW+1)'(DEPTH);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem_q[rp_q[PW-1:0]];

    always_comb
    begin
        wp_d = wp_q + (PW+1)'(in_valid && in_ready);
        rp_d = rp_q + (PW+1)'(out_valid && out_ready);
        if (flush)
        begin
            wp_d = '0;
            rp_d = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (in_valid && in_ready)
            mem_q[wp_q[PW-1:0]] <= in_data;
    end
endmodule : wr_fifo

module spi_eeprom
    import eeprom_pkg::*;
#(
    parameter int ADDR_W     = eeprom_pkg::ARRAY_ADDR_W,
    parameter int WRITE_CYCS = eeprom_pkg::WRITE_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // serial pins
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so,
    output logic      so_oe_n,
    // state seen from outside
    output logic      busy,
    output logic      write_latch,
    output logic      standby
);
    import eeprom_pkg::*;

    if (ADDR_W < 8 || ADDR_W > ARRAY_ADDR_W || WRITE_CYCS < 1)
    begin : g_param_chk
        $error("unsupported address width or write time");
    end

    typedef enum logic [3:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA,
                              ST_SRD, ST_SWR, ST_LATCH, ST_IGNORE} state_t;
    localparam int TW = $clog2(WRITE_CYCS + 1);

    // input synchroniser, two flops per pin
    pins_t pin_raw, s1_q, s2_q;
    assign pin_raw = '{sck: sck, cs_n: cs_n, si: si, hold_n: hold_n, wp_n: wp_n};
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
            s2_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
        end
        else
        begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
        end
    end

    logic [7:0] mem_q [2**ADDR_W];
    logic [7:0] id_q  [2**ID_ADDR_W];

    state_t          state_q, state_d;
    logic [2:0]      cnt_q, cnt_d;
    logic [1:0]      nbyte_q, nbyte_d;
    logic [7:0]      rx_q, rx_d, tx_q, tx_d, sr_val_q, sr_val_d;
    logic [15:0]     addr_q, addr_d;
    logic            wr_q, wr_d, tx_act_q, tx_act_d, so_q, so_d, so_en_q, so_en_d;
    logic            set_q, set_d, abort_q, abort_d, pend_q, pend_d;
    logic            gpe_q, gpe_d, ips_q, ips_d, lock_q, lock_d, wel_q, wel_d, busy_q, busy_d;
    logic [1:0]      bg_q, bg_d;
    logic [TW-1:0]   wt_q, wt_d;
    logic            sck_p_q, cs_p_q, wp_p_q;

    logic            hold_act, rise, fall, cs_rise, cs_fall, byte_done, guard_on;
    logic [7:0]      rx_n, status, rd_byte;
    logic [15:0]     rd_addr;
    logic            prot, push, fifo_rdy, fifo_vld, flush;
    wr_entry_t       push_e, pop_e;

    assign hold_act  = !s2_q.hold_n && !s2_q.cs_n;
    // edges ignored while held
    assign rise      = s2_q.sck && !sck_p_q && !s2_q.cs_n && !hold_act;
    assign fall      = !s2_q.sck && sck_p_q && !s2_q.cs_n && !hold_act;
    assign cs_rise   = s2_q.cs_n && !cs_p_q;
    assign cs_fall   = !s2_q.cs_n && cs_p_q;
    assign byte_done = rise && cnt_q == 3'h7;
    assign rx_n      = {rx_q[6:0], s2_q.si};
    assign status    = {gpe_q, ips_q, 1'b0, lock_q, bg_q, wel_q, busy_q};
    assign guard_on  = gpe_q && !s2_q.wp_n;

    // read source: id page by low six bits, array by low address bits
    always_comb
    begin
        rd_addr = (state_q == ST_ADDR) ? {addr_q[7:0], rx_n} : addr_q + 16'h0001;
        if (ips_q)
            rd_byte = id_q[rd_addr[ID_ADDR_W-1:0]];
        else
            rd_byte = mem_q[rd_addr[ADDR_W-1:0]];
    end

    // block guard decode for the byte being taken
    always_comb
    begin
        if (ips_q)
            prot = lock_q || bg_q == 2'h3;
        else
        begin
            case (bg_q)
                2'h1:    prot = addr_q[ADDR_W-1 -: 2] == 2'h3;
                2'h2:    prot = addr_q[ADDR_W-1];
                2'h3:    prot = 1'b1;
                default: prot = 1'b0;
            endcase
        end
    end

    assign push   = state_q == ST_WDATA && byte_done && wel_q && !prot && fifo_rdy;
    assign push_e = '{is_id: ips_q, addr: addr_q[ARRAY_ADDR_W-1:0], data: rx_n};

    always_comb
    begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        nbyte_d  = nbyte_q;
        rx_d     = rx_q;
        tx_d     = tx_q;
        tx_act_d = tx_act_q;
        so_d     = so_q;
        so_en_d  = so_en_q;
        addr_d   = addr_q;
        wr_d     = wr_q;
        set_d    = set_q;
        sr_val_d = sr_val_q;
        abort_d  = abort_q;
        pend_d   = pend_q;
        gpe_d    = gpe_q;
        ips_d    = ips_q;
        lock_d   = lock_q;
        bg_d     = bg_q;
        wel_d    = wel_q;
        busy_d   = busy_q;
        wt_d     = wt_q;
        flush    = 1'b0;
        if (cs_fall)
        begin
            // a new frame opens only on a falling select
            state_d = ST_CMD;
            cnt_d   = '0;
            nbyte_d = '0;
            abort_d = 1'b0;
        end
        if (rise)
        begin
            rx_d  = rx_n;
            cnt_d = cnt_q + 3'h1;
            case (state_q)
                ST_CMD:
                    if (byte_done)
                    begin
                        if (busy_q && rx_n != OP_SR_READ)
                            state_d = ST_IGNORE;
                        else
                        begin
                            case (rx_n)
                                OP_SR_READ:
                                begin
                                    state_d  = ST_SRD;
                                    tx_d     = status;
                                    tx_act_d = 1'b1;
                                end
                                OP_READ, OP_WRITE:
                                begin
                                    state_d = ST_ADDR;
                                    wr_d    = rx_n == OP_WRITE;
                                end
                                OP_LATCH_SET, OP_LATCH_CLR:
                                begin
                                    state_d = ST_LATCH;
                                    set_d   = rx_n == OP_LATCH_SET;
                                end
                                OP_SR_WRITE: state_d = ST_SWR;
                                default:     state_d = ST_IGNORE;
                            endcase
                        end
                    end
                ST_ADDR:
                    if (byte_done)
                    begin
                        addr_d  = {addr_q[7:0], rx_n};
                        nbyte_d = nbyte_q + 2'h1;
                        if (nbyte_q == 2'h1)
                        begin
                            nbyte_d  = '0;
                            state_d  = wr_q ? ST_WDATA : ST_RDATA;
                            tx_d     = rd_byte;
                            tx_act_d = !wr_q;
                        end
                    end
                ST_RDATA:
                    if (byte_done)
                    begin
                        addr_d = rd_addr;
                        tx_d   = rd_byte;
                    end
                ST_SRD:
                    if (byte_done)
                        tx_d = status;
                ST_SWR:
                    if (nbyte_q != '0)
                        state_d = ST_IGNORE;
                    else if (byte_done)
                    begin
                        sr_val_d = rx_n;
                        nbyte_d  = 2'h1;
                    end
                ST_WDATA:
                    if (byte_done)
                    begin
                        addr_d[ID_ADDR_W-1:0] = addr_q[ID_ADDR_W-1:0] + 6'h01;
                        nbyte_d               = 2'h1;
                    end
                ST_LATCH: state_d = ST_IGNORE;
                default: ;
            endcase
        end
        if (fall && tx_act_q)
        begin
            so_d    = tx_q[7];
            tx_d    = {tx_q[6:0], 1'b0};
            so_en_d = 1'b1;
        end
        // guard pin falling inside a status write frame
        if (state_q == ST_SWR && gpe_q && wp_p_q && !s2_q.wp_n)
            abort_d = 1'b1;
        if (cs_rise)
        begin
            state_d  = ST_IDLE;
            tx_act_d = 1'b0;
            so_en_d  = 1'b0;
            flush    = !busy_q;
            if (state_q == ST_LATCH)
                wel_d = set_q;
            if (state_q == ST_RDATA || state_q == ST_WDATA)
                ips_d = 1'b0;
            if (cnt_q == '0 && nbyte_q == 2'h1 && wel_q && !busy_q)
            begin
                // exact length frames only
                if (state_q == ST_SWR && !guard_on && !abort_q)
                begin
                    busy_d = 1'b1;
                    pend_d = 1'b1;
                    wt_d   = TW'(WRITE_CYCS);
                end
                if (state_q == ST_WDATA && fifo_vld)
                begin
                    busy_d = 1'b1;
                    flush  = 1'b0;
                    wt_d   = TW'(WRITE_CYCS);
                end
            end
        end
        if (busy_q)
        begin
            // guard pin not consulted once programming runs
            wt_d = wt_q - TW'(1);
            if (wt_q == TW'(1))
            begin
                busy_d = 1'b0;
                wel_d  = 1'b0;
                pend_d = 1'b0;
                if (pend_q)
                begin
                    gpe_d = sr_val_q[SR_GUARD_EN];
                    bg_d  = {sr_val_q[SR_BG_HIGH], sr_val_q[SR_BG_LOW]};
                    // page select and lock never set together
                    if (!(sr_val_q[SR_ID_SEL] && sr_val_q[SR_ID_LOCK]))
                    begin
                        ips_d  = sr_val_q[SR_ID_SEL];
                        lock_d = sr_val_q[SR_ID_LOCK];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q  <= ST_IDLE;
            cnt_q    <= '0;
            nbyte_q  <= '0;
            rx_q     <= '0;
            tx_q     <= '0;
            tx_act_q <= 1'b0;
            so_q     <= 1'b0;
            so_en_q  <= 1'b0;
            addr_q   <= '0;
            wr_q     <= 1'b0;
            set_q    <= 1'b0;
            sr_val_q <= SR_RESET;
            abort_q  <= 1'b0;
            pend_q   <= 1'b0;
            gpe_q    <= SR_RESET[SR_GUARD_EN];
            ips_q    <= SR_RESET[SR_ID_SEL];
            lock_q   <= SR_RESET[SR_ID_LOCK];
            bg_q     <= SR_RESET[SR_BG_HIGH:SR_BG_LOW];
            wel_q    <= SR_RESET[SR_LATCH];
            busy_q   <= SR_RESET[SR_BUSY];
            wt_q     <= '0;
            sck_p_q  <= 1'b0;
            cs_p_q   <= 1'b1;
            wp_p_q   <= 1'b1;
        end
        else
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            nbyte_q  <= nbyte_d;
            rx_q     <= rx_d;
            tx_q     <= tx_d;
            tx_act_q <= tx_act_d;
            so_q     <= so_d;
            so_en_q  <= so_en_d;
            addr_q   <= addr_d;
            wr_q     <= wr_d;
            set_q    <= set_d;
            sr_val_q <= sr_val_d;
            abort_q  <= abort_d;
            pend_q   <= pend_d;
            gpe_q    <= gpe_d;
            ips_q    <= ips_d;
            lock_q   <= lock_d;
            bg_q     <= bg_d;
            wel_q    <= wel_d;
            busy_q   <= busy_d;
            wt_q     <= wt_d;
            sck_p_q  <= s2_q.sck;
            cs_p_q   <= s2_q.cs_n;
            wp_p_q   <= s2_q.wp_n;
        end
    end

    // bytes queued during the frame, programmed while busy
    wr_fifo #(.WIDTH($bits(wr_entry_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .flush     (flush),
        .in_valid  (push),
        .in_ready  (fifo_rdy),
        .in_data   (push_e),
        .out_valid (fifo_vld),
        .out_ready (busy_q),
        .out_data  (pop_e)
    );

    always_ff @(posedge clk)
    begin
        if (fifo_vld && busy_q)
        begin
            if (pop_e.is_id)
                id_q[pop_e.addr[ID_ADDR_W-1:0]] <= pop_e.data;
            else
                mem_q[pop_e.addr[ADDR_W-1:0]] <= pop_e.data;
        end
    end

    assign so          = so_q;
    assign so_oe_n     = !so_en_q || hold_act;
    assign busy        = busy_q;
    assign write_latch = wel_q;
    assign standby     = state_q == ST_IDLE && !busy_q;

    // checks
    wel_clear_a: assert property (@(posedge clk) disable iff (!nrst) $fell(busy_q) |-> !wel_q)
        else $error("write latch not cleared after programming");
    busy_hold_a: assert property (@(posedge clk) disable iff (!nrst) busy_q && wt_q > TW'(1) |=> busy_q)
        else $error("busy dropped early");
    guard_rej_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_SWR && cs_rise && guard_on && !busy_q |=> !busy_q)
        else $error("status write accepted under guard");
    wp_abort_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_SWR && cs_rise && abort_q && !busy_q |=> !busy_q)
        else $error("aborted status write started");
    sr_mask_a: assert property (@(posedge clk) disable iff (!nrst)
        busy_q && pend_q && wt_q == TW'(1) |=> gpe_q == sr_val_q[SR_GUARD_EN] && !status[SR_ZERO])
        else $error("status write result wrong");
    hold_hiz_a: assert property (@(posedge clk) disable iff (!nrst) hold_act |-> so_oe_n)
        else $error("output driven during hold");
    cs_stop_a: assert property (@(posedge clk) disable iff (!nrst) cs_rise |=> so_oe_n && !tx_act_q)
        else $error("output not released on deselect");
    busy_ign_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_CMD && busy_q && byte_done && rx_n != OP_SR_READ && !cs_rise |=> state_q == ST_IGNORE)
        else $error("command taken while busy");
    bad_op_a: assert property (@(posedge clk) disable iff (!nrst) state_q == ST_IGNORE |-> so_oe_n)
        else $error("output driven after unknown opcode");
    rd_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_RDATA && byte_done && !cs_rise && addr_q == 16'hffff |=> addr_q == 16'h0000)
        else $error("read address did not wrap");
    sr_busy_c:  cover property (@(posedge clk) disable iff (!nrst) state_q == ST_SRD && busy_q && fall);
    rd_wrap_c:  cover property (@(posedge clk) disable iff (!nrst) state_q == ST_RDATA && byte_done && &addr_q);
    sr_done_c:  cover property (@(posedge clk) disable iff (!nrst) busy_q && pend_q && wt_q == TW'(1));
endmodule : spi_eeprom

/* File: tb/spi_host_model.sv */
// serial host model that drives the eeprom pins
`timescale 1ns/1ps
module spi_host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    input  wire logic so,
    input  wire logic so_oe_n
);
    logic drove;
    logic held;
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic sel();
        @(posedge clk);
        cs_n <= 1'b0;
        drove = 1'b0;
        repeat (4) @(posedge clk);
    endtask : sel
    task automatic desel();
        @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge clk);
    endtask : desel
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            si <= tx[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            // a released line shows the opposite of the stale bit
            rx[i] = so_oe_n ? ~so : so;
            if (so_oe_n === 1'b0)
                drove = 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
    endtask : xb
    task automatic pause();
        repeat (4) @(posedge clk);
        hold_n <= 1'b0;
        repeat (4) @(posedge clk);
        // a clock pulse with moving data while held must be ignored
        sck <= 1'b1;
        si  <= ~si;
        repeat (4) @(posedge clk);
        held = so_oe_n;
        sck <= 1'b0;
        repeat (4) @(posedge clk);
        hold_n <= 1'b1;
    endtask : pause
endmodule : spi_host_model

/* File: tb/spi_eeprom_tb_top.sv */
// self-checking bench of the serial eeprom slave
`timescale 1ns/1ps
module spi_eeprom_tb_top;
    import eeprom_pkg::*;
    logic       clk, nrst, wp_n, sck, cs_n, si, hold_n, so, so_oe_n, busy, write_latch, standby;
    logic [7:0] v;
    logic [7:0] w;
    int         num_errors = 0;
    int         total_checks = 0;
    int         cycles = 0;
    spi_eeprom #(.WRITE_CYCS(400)) u_dut (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .busy(busy), .write_latch(write_latch),
        .standby(standby));
    spi_host_model u_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
        .so_oe_n(so_oe_n));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic chk8(input logic [7:0] exp, input logic [7:0] got, input logic [7:0] m);
        total_checks++;
        if ((got & m) !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t exp %h got %h", $time, exp, got);
        end
    endtask : chk8
    task automatic chk1(input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t exp %h got %h", $time, exp, got);
        end
    endtask : chk1
    task automatic frame(input logic [7:0] tx[$]);
        logic [7:0] rx;
        u_host.sel();
        foreach (tx[i])
        begin
            u_host.xb(tx[i], rx);
            v = w;
            w = rx;
        end
        u_host.desel();
    endtask : frame
    task automatic poll();
        for (int i = 0; i < 8; i++)
        begin
            frame({OP_SR_READ, 8'h00});
            if (w[SR_BUSY] === 1'b0)
                break;
        end
        frame({OP_SR_READ, 8'h00});
    endtask : poll
    task automatic sr_wr(input logic [7:0] d);
        frame({OP_LATCH_SET});
        frame({OP_SR_WRITE, d});
    endtask : sr_wr
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        frame({OP_LATCH_SET});
        frame({OP_WRITE, a[15:8], a[7:0], d});
        poll();
    endtask : wr
    task automatic t_status();
        chk1(1'b0, busy);
        chk1(1'b1, standby);
        frame({OP_SR_READ, 8'h00});
        chk8(8'h00, w, 8'hff);
        frame({OP_LATCH_SET});
        chk1(1'b1, write_latch);
        frame({OP_LATCH_CLR});
        chk1(1'b0, write_latch);
        sr_wr(8'hff);
        chk1(1'b1, busy);
        frame({OP_SR_READ, 8'h00});
        chk8(8'h03, w, 8'hff);
        poll();
        chk8(8'h8c, w, 8'hff);
    endtask : t_status
    task automatic t_guard();
        wp_n <= 1'b0;
        sr_wr(8'h00);
        chk1(1'b0, busy);
        wp_n <= 1'b1;
        frame({OP_LATCH_SET});
        u_host.sel();
        u_host.xb(OP_SR_WRITE, w);
        wp_n <= 1'b0;
        u_host.xb(8'h00, w);
        wp_n <= 1'b1;
        u_host.desel();
        chk1(1'b0, busy);
        frame({OP_SR_READ, 8'h00});
        chk8(8'h8c, w, 8'hfd);
        sr_wr(8'h0c);
        wp_n <= 1'b0;
        poll();
        chk8(8'h0c, w, 8'hff);
        sr_wr(8'h00);
        chk1(1'b1, busy);
        poll();
        chk8(8'h00, w, 8'hff);
        wp_n <= 1'b1;
    endtask : t_guard
    task automatic t_array();
        wr(16'h7fff, 8'ha5);
        chk1(1'b0, write_latch);
        wr(16'h0000, 8'h5a);
        frame({OP_READ, 8'hff, 8'hff, 8'h00, 8'h00});
        chk8(8'ha5, v, 8'hff);
        chk8(8'h5a, w, 8'hff);
        chk1(1'b1, so_oe_n);
        frame({OP_LATCH_SET});
        frame({OP_WRITE, 8'h00, 8'h01, 8'h11});
        frame({OP_READ, 8'h00, 8'h00, 8'h00});
        chk1(1'b0, u_host.drove);
        poll();
        frame({8'hff, 8'h00});
        chk1(1'b0, u_host.drove);
        // pause between the last address byte and the data byte of an array read
        u_host.sel();
        u_host.xb(OP_READ, w);
        u_host.xb(8'h00, w);
        u_host.xb(8'h01, w);
        u_host.pause();
        chk1(1'b1, u_host.held);
        u_host.xb(8'h00, w);
        u_host.desel();
        chk8(8'h11, w, 8'hff);
    endtask : t_array
    task automatic t_idpage();
        sr_wr(8'h40);
        poll();
        chk8(8'h40, w, 8'hff);
        frame({OP_LATCH_SET});
        frame({OP_WRITE, 8'hff, 8'hfe, 8'h77, 8'h88});
        poll();
        chk8(8'h00, w, 8'hff);
        sr_wr(8'h40);
        poll();
        // the last two bytes of the page and no further
        frame({OP_READ, 8'h00, 8'h3e, 8'h00, 8'h00});
        chk8(8'h77, v, 8'hff);
        chk8(8'h88, w, 8'hff);
        frame({OP_SR_READ, 8'h00});
        chk8(8'h00, w, 8'hff);
    endtask : t_idpage
    initial
    begin
        nrst = 1'b0;
        wp_n = 1'b1;
        v = 8'h00;
        w = 8'h00;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_status();
        t_guard();
        t_array();
        t_idpage();
        complete_run();
    end
endmodule : spi_eeprom_tb_top
